/* File: include/cfg_bank_pkg.sv */
// shared constants and carrier types for the synthesizer config bank
`default_nettype none
package cfg_bank_pkg;
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned SEL_BITS = 3;
  localparam int unsigned NUM_REGS = 8;
  localparam int unsigned CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h18;

  // register select codes
  localparam logic [2:0] SEL_INT = 3'h0;
  localparam logic [2:0] SEL_MOD = 3'h1;
  localparam logic [2:0] SEL_FRAC = 3'h2;
  localparam logic [2:0] SEL_DITH = 3'h3;
  localparam logic [2:0] SEL_PUMP = 3'h4;
  localparam logic [2:0] SEL_LO = 3'h5;
  localparam logic [2:0] SEL_OSC = 3'h6;
  localparam logic [2:0] SEL_XOSC = 3'h7;

  // field positions (lsb) inside a 24-bit word
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned DATA_LSB = 3;
  localparam int unsigned DIVSEL_BIT = 10;
  localparam int unsigned DITH_MAG_LSB = 21;
  localparam int unsigned DITH_EN_BIT = 20;
  localparam int unsigned MUX_LSB = 21;
  localparam int unsigned REFSRC_LSB = 19;
  localparam int unsigned PREF_BIT = 18;
  localparam int unsigned POL_BIT = 17;
  localparam int unsigned POFF_LSB = 12;
  localparam int unsigned PMULT_LSB = 10;
  localparam int unsigned PSRC_BIT = 9;
  localparam int unsigned PCTL_LSB = 7;
  localparam int unsigned EDGE_LSB = 5;
  localparam int unsigned ABL_LSB = 3;
  localparam int unsigned CDAC_LSB = 8;
  localparam int unsigned MBE_BIT = 7;
  localparam int unsigned PLLEN_BIT = 6;
  localparam int unsigned LO_DIV_2_3_SELECT_BIT = 5;
  localparam int unsigned LDIR_BIT = 4;
  localparam int unsigned LO_OUT_DRIVER_ENABLE_BIT = 3;
  localparam int unsigned PEN_BIT = 20;
  localparam int unsigned L33_BIT = 19;
  localparam int unsigned OLDO_BIT = 18;
  localparam int unsigned OEN_BIT = 17;
  localparam int unsigned OSW_BIT = 16;
  localparam int unsigned AMP_LSB = 10;
  localparam int unsigned BSRC_BIT = 9;
  localparam int unsigned BSEL_LSB = 3;
  localparam int unsigned XOSC_BIT = 22;

  localparam logic [WORD_BITS-1:0] REG_RESET = 24'h000000;

  // decoded configuration fields driven to the analog core
  typedef struct packed {
    logic divide_select;
    logic [6:0] integer_ratio;
    logic [10:0] modulus_value;
    logic [10:0] fraction_value;
    logic [1:0] dither_magnitude;
    logic dither_enable;
    logic [16:0] dither_restart;
    logic [2:0] out_mux_source;
    logic [1:0] ref_path_source;
    logic pump_ref_select;
    logic offset_polarity;
    logic [4:0] phase_offset_value;
    logic [1:0] pump_current_mult;
    logic pump_control_source;
    logic [1:0] pump_control;
    logic [1:0] detector_edge_sense;
    logic [1:0] antibacklash_delay;
    logic [3:0] cap_dac_value;
    logic mixer_bias_enable;
    logic pll_enable;
    logic lo_div_2_3_select;
    logic lo_port_direction;
    logic lo_out_driver_enable;
    logic pump_enable;
    logic ldo33_enable;
    logic osc_ldo_enable;
    logic osc_enable;
    logic osc_switch_control;
    logic [5:0] osc_amplitude;
    logic band_select_source;
    logic [5:0] band_select;
    logic ext_osc_enable;
  } cfg_fields_s;
endpackage
`default_nettype wire

/* File: design/spi_word_shifter.sv */
// serial shifter on the link clock, hands whole words over with a ready flag
`default_nettype none
module spi_word_shifter #(
  parameter int unsigned WIDTH = cfg_bank_pkg::WORD_BITS
) (
  input wire logic spi_clk_i,
  input wire logic spi_le_i,
  input wire logic spi_data_i,
  output logic [WIDTH-1:0] word_o,
  output logic word_tgl_o
);
  // ****************************************************
  // link-side state
  // ****************************************************
  typedef struct packed {
    logic [WIDTH-1:0] shift;
    logic [cfg_bank_pkg::CNT_BITS-1:0] count;
    logic [WIDTH-1:0] word;
    logic tgl;
  } link_s;

  link_s state;
  link_s next_state;

  initial begin
    if (WIDTH != cfg_bank_pkg::WORD_BITS) begin
      $error("shifter width must match word width");
    end
  end

  // shift while latch low; latch high closes the frame
  // ready flag is a level, not a toggle: an unreset toggle would
  // never leave its unknown start value
  always_comb begin
    next_state = state;
    if (!spi_le_i) begin
      next_state.shift = {state.shift[WIDTH-2:0], spi_data_i};
      next_state.tgl = 1'b0;
      if (state.count != cfg_bank_pkg::CNT_FULL) begin
        next_state.count = state.count + 5'h01;
      end
    end else begin
      next_state.tgl = 1'b0;
      if (state.count == cfg_bank_pkg::CNT_FULL) begin
        next_state.word = state.shift;
        next_state.tgl = 1'b1;
      end
      next_state.count = '0;
    end
  end

  // no reset here: link clock may stand still; the ready flag
  // settles on the first link edge of any frame
  always_ff @(posedge spi_clk_i) begin
    state <= next_state;
  end

  assign word_o = state.word;
  assign word_tgl_o = state.tgl;
endmodule // spi_word_shifter
`default_nettype wire

/* File: design/pll_mixer_config_registers.sv */
// configuration register bank loaded over the three-wire serial port
`default_nettype none
//
// Function
// - eight 24-bit registers, serially loaded
// - low three bits pick the register
// - select 0: divide mode and integer ratio
// - select 1: eleven-bit modulus
// - select 2: eleven-bit fraction
// - select 3: dither magnitude, enable, restart
// - select 4: mux, ref, pump, offset
// - select 5: cap dac and LO enables
// - select 6: pump, regulator, oscillator enables
// - select 7: external oscillator enable only
// - divider writes start band calibration
// - divide select 0 fractional, 1 integer
module pll_mixer_config_registers #(
  parameter int unsigned WORD_WIDTH = cfg_bank_pkg::WORD_BITS
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CLK_EN_I,
  input wire logic SPI_CLK_I,
  input wire logic SPI_LE_I,
  input wire logic SPI_DATA_I,
  output logic [WORD_WIDTH-1:0] REG_WORD_O [cfg_bank_pkg::NUM_REGS],
  output cfg_bank_pkg::cfg_fields_s CFG_O,
  output logic INTEGER_MODE_O,
  output logic CAL_START_O,
  output logic WRITE_STROBE_O,
  output logic [cfg_bank_pkg::SEL_BITS-1:0] WRITE_SEL_O
);
  // ****************************************************
  // elaboration checks
  // ****************************************************
  initial begin
    if (WORD_WIDTH != cfg_bank_pkg::WORD_BITS) begin
      $error("word width must be 24");
    end
  end

  // ****************************************************
  // link domain
  // ****************************************************
  logic [WORD_WIDTH-1:0] link_word;
  logic link_tgl;

  spi_word_shifter #(
    .WIDTH(WORD_WIDTH)
  ) u_shifter (
    .spi_clk_i(SPI_CLK_I),
    .spi_le_i(SPI_LE_I),
    .spi_data_i(SPI_DATA_I),
    .word_o(link_word),
    .word_tgl_o(link_tgl)
  );

  // ****************************************************
  // system domain state
  // ****************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_COMMIT = 2'b10
  } load_e;

  typedef struct packed {
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_seen;
    load_e fsm;
    logic [WORD_WIDTH-1:0] hold;
    logic [cfg_bank_pkg::NUM_REGS-1:0][WORD_WIDTH-1:0] regs;
    logic cal;
    logic strobe;
    logic [cfg_bank_pkg::SEL_BITS-1:0] sel;
  } sys_s;

  sys_s state;
  sys_s next_state;
  logic [cfg_bank_pkg::SEL_BITS-1:0] hold_sel;

  assign hold_sel = state.hold[cfg_bank_pkg::SEL_LSB +: 3];

  // ready-flag crossing, then a short fsm; the word is stable in the
  // link domain for many link cycles after the flag rises, so a
  // four-cycle-late capture of the whole bus is safe
  always_comb begin
    next_state = state;
    next_state.tgl_meta = link_tgl;
    next_state.tgl_sync = state.tgl_meta;
    next_state.tgl_seen = state.tgl_sync;
    next_state.cal = 1'b0;
    next_state.strobe = 1'b0;
    case (state.fsm)
      ST_IDLE: begin
        // rising edge of the synced ready flag starts a capture
        if (state.tgl_sync && !state.tgl_seen) begin
          next_state.fsm = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        next_state.hold = link_word;
        next_state.fsm = ST_COMMIT;
      end
      ST_COMMIT: begin
        next_state.regs[hold_sel] = state.hold;
        next_state.strobe = 1'b1;
        next_state.sel = hold_sel;
        if (hold_sel == cfg_bank_pkg::SEL_INT ||
            hold_sel == cfg_bank_pkg::SEL_MOD ||
            hold_sel == cfg_bank_pkg::SEL_FRAC) begin
          next_state.cal = 1'b1;
        end
        next_state.fsm = ST_IDLE;
      end
      default: begin
        next_state.fsm = ST_IDLE;
      end
    endcase
  end

  // synchronous reset; enable freezes all system-domain state, not the link shifter
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state.tgl_meta <= 1'b0;
      state.tgl_sync <= 1'b0;
      state.tgl_seen <= 1'b0;
      state.fsm <= ST_IDLE;
      state.hold <= cfg_bank_pkg::REG_RESET;
      state.regs <= '0;
      state.cal <= 1'b0;
      state.strobe <= 1'b0;
      state.sel <= '0;
    end else if (CLK_EN_I) begin
      state <= next_state;
    end
  end

  // reset leaves seen==sync==0 while link ready may be 1: one
  // spurious commit of a stale word can follow reset; host should
  // reprogram after reset anyway

  // ****************************************************
  // outputs
  // ****************************************************
  genvar gi;
  generate
    for (gi = 0; gi < cfg_bank_pkg::NUM_REGS; gi++) begin : g_word
      assign REG_WORD_O[gi] = state.regs[gi];
    end
  endgenerate

  assign CAL_START_O = state.cal;
  assign WRITE_STROBE_O = state.strobe;
  assign WRITE_SEL_O = state.sel;

  logic [WORD_WIDTH-1:0] r0, r1, r2, r3, r4, r5, r6, r7;
  assign r0 = state.regs[cfg_bank_pkg::SEL_INT];
  assign r1 = state.regs[cfg_bank_pkg::SEL_MOD];
  assign r2 = state.regs[cfg_bank_pkg::SEL_FRAC];
  assign r3 = state.regs[cfg_bank_pkg::SEL_DITH];
  assign r4 = state.regs[cfg_bank_pkg::SEL_PUMP];
  assign r5 = state.regs[cfg_bank_pkg::SEL_LO];
  assign r6 = state.regs[cfg_bank_pkg::SEL_OSC];
  assign r7 = state.regs[cfg_bank_pkg::SEL_XOSC];

  // field decode; reserved bits reach only REG_WORD_O, never CFG_O
  always_comb begin
    CFG_O.divide_select = r0[cfg_bank_pkg::DIVSEL_BIT];
    CFG_O.integer_ratio = r0[cfg_bank_pkg::DATA_LSB +: 7];
    CFG_O.modulus_value = r1[cfg_bank_pkg::DATA_LSB +: 11];
    CFG_O.fraction_value = r2[cfg_bank_pkg::DATA_LSB +: 11];
    CFG_O.dither_magnitude = r3[cfg_bank_pkg::DITH_MAG_LSB +: 2];
    CFG_O.dither_enable = r3[cfg_bank_pkg::DITH_EN_BIT];
    CFG_O.dither_restart = r3[cfg_bank_pkg::DATA_LSB +: 17];
    CFG_O.out_mux_source = r4[cfg_bank_pkg::MUX_LSB +: 3];
    CFG_O.ref_path_source = r4[cfg_bank_pkg::REFSRC_LSB +: 2];
    CFG_O.pump_ref_select = r4[cfg_bank_pkg::PREF_BIT];
    CFG_O.offset_polarity = r4[cfg_bank_pkg::POL_BIT];
    CFG_O.phase_offset_value = r4[cfg_bank_pkg::POFF_LSB +: 5];
    CFG_O.pump_current_mult = r4[cfg_bank_pkg::PMULT_LSB +: 2];
    CFG_O.pump_control_source = r4[cfg_bank_pkg::PSRC_BIT];
    CFG_O.pump_control = r4[cfg_bank_pkg::PCTL_LSB +: 2];
    CFG_O.detector_edge_sense = r4[cfg_bank_pkg::EDGE_LSB +: 2];
    CFG_O.antibacklash_delay = r4[cfg_bank_pkg::ABL_LSB +: 2];
    CFG_O.cap_dac_value = r5[cfg_bank_pkg::CDAC_LSB +: 4];
    CFG_O.mixer_bias_enable = r5[cfg_bank_pkg::MBE_BIT];
    CFG_O.pll_enable = r5[cfg_bank_pkg::PLLEN_BIT];
    CFG_O.lo_div_2_3_select = r5[cfg_bank_pkg::LO_DIV_2_3_SELECT_BIT];
    CFG_O.lo_port_direction = r5[cfg_bank_pkg::LDIR_BIT];
    CFG_O.lo_out_driver_enable = r5[cfg_bank_pkg::LO_OUT_DRIVER_ENABLE_BIT];
    CFG_O.pump_enable = r6[cfg_bank_pkg::PEN_BIT];
    CFG_O.ldo33_enable = r6[cfg_bank_pkg::L33_BIT];
    CFG_O.osc_ldo_enable = r6[cfg_bank_pkg::OLDO_BIT];
    CFG_O.osc_enable = r6[cfg_bank_pkg::OEN_BIT];
    CFG_O.osc_switch_control = r6[cfg_bank_pkg::OSW_BIT];
    CFG_O.osc_amplitude = r6[cfg_bank_pkg::AMP_LSB +: 6];
    CFG_O.band_select_source = r6[cfg_bank_pkg::BSRC_BIT];
    CFG_O.band_select = r6[cfg_bank_pkg::BSEL_LSB +: 6];
    CFG_O.ext_osc_enable = r7[cfg_bank_pkg::XOSC_BIT];
  end

  assign INTEGER_MODE_O = r0[cfg_bank_pkg::DIVSEL_BIT];
endmodule // pll_mixer_config_registers
`default_nettype wire

/* File: test/cfg_bank_assertions.sv */
// concurrent checks on the config bank outputs
`default_nettype none
module cfg_bank_checker #(
  parameter int unsigned WORD_WIDTH = cfg_bank_pkg::WORD_BITS
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [WORD_WIDTH-1:0] REG_WORD_O [cfg_bank_pkg::NUM_REGS],
  input wire cfg_bank_pkg::cfg_fields_s CFG_O,
  input wire logic INTEGER_MODE_O,
  input wire logic CAL_START_O,
  input wire logic WRITE_STROBE_O,
  input wire logic [cfg_bank_pkg::SEL_BITS-1:0] WRITE_SEL_O
);
  // ****************
  // commit timing
  // ****************
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // commit pulse and divider commit
  sequence pulse_s;
    WRITE_STROBE_O ##1 !WRITE_STROBE_O;
  endsequence
  sequence div_commit_s;
    WRITE_STROBE_O && WRITE_SEL_O < 3'h3;
  endsequence
  chk_strobe_pulse: assert property (WRITE_STROBE_O |-> pulse_s)
    else $error("strobe wider than one cycle");
  chk_cal_on_div: assert property (div_commit_s |-> CAL_START_O)
    else $error("divider write without calibration");
  chk_cal_only_div: assert property (CAL_START_O |-> div_commit_s)
    else $error("calibration without divider write");
  chk_sel_in_word: assert property (WRITE_STROBE_O |->
    REG_WORD_O[WRITE_SEL_O][2:0] == WRITE_SEL_O)
    else $error("word stored under wrong select");
  // outputs only move on a commit, so a missed hold shows here
  chk_quiet_hold: assert property (!WRITE_STROBE_O |->
    $stable(CFG_O) && $stable(INTEGER_MODE_O))
    else $error("fields changed without commit");
  // ****************
  // field placement
  // ****************
  chk_int_map: assert property ({CFG_O.divide_select,
    CFG_O.integer_ratio, INTEGER_MODE_O} == {REG_WORD_O[0][10:3],
    REG_WORD_O[0][10]}) else $error("integer fields misplaced");
  chk_mod_map: assert property (CFG_O.modulus_value ==
    REG_WORD_O[1][13:3]) else $error("modulus misplaced");
  chk_frac_map: assert property (CFG_O.fraction_value ==
    REG_WORD_O[2][13:3]) else $error("fraction misplaced");
  chk_dith_map: assert property ({CFG_O.dither_magnitude,
    CFG_O.dither_enable, CFG_O.dither_restart} == REG_WORD_O[3][22:3])
    else $error("dither fields misplaced");
  chk_pump_map: assert property ({CFG_O.out_mux_source,
    CFG_O.ref_path_source, CFG_O.pump_ref_select, CFG_O.offset_polarity,
    CFG_O.phase_offset_value, CFG_O.pump_current_mult,
    CFG_O.pump_control_source, CFG_O.pump_control, CFG_O.detector_edge_sense,
    CFG_O.antibacklash_delay} == REG_WORD_O[4][23:3])
    else $error("pump fields misplaced");
  chk_lo_map: assert property ({CFG_O.cap_dac_value,
    CFG_O.mixer_bias_enable, CFG_O.pll_enable, CFG_O.lo_div_2_3_select,
    CFG_O.lo_port_direction, CFG_O.lo_out_driver_enable} ==
    REG_WORD_O[5][11:3]) else $error("lo fields misplaced");
  chk_osc_map: assert property ({CFG_O.pump_enable,
    CFG_O.ldo33_enable, CFG_O.osc_ldo_enable, CFG_O.osc_enable,
    CFG_O.osc_switch_control, CFG_O.osc_amplitude, CFG_O.band_select_source,
    CFG_O.band_select} == REG_WORD_O[6][20:3])
    else $error("oscillator fields misplaced");
  chk_xosc_map: assert property (CFG_O.ext_osc_enable ==
    REG_WORD_O[7][22]) else $error("external osc bit misplaced");
endmodule // cfg_bank_checker

bind pll_mixer_config_registers cfg_bank_checker #(.WORD_WIDTH(WORD_WIDTH))
  checker_i (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
  .REG_WORD_O(REG_WORD_O), .CFG_O(CFG_O), .INTEGER_MODE_O(INTEGER_MODE_O),
  .CAL_START_O(CAL_START_O), .WRITE_STROBE_O(WRITE_STROBE_O),
  .WRITE_SEL_O(WRITE_SEL_O));
`default_nettype wire

/* File: test/spi_host_model.sv */
// host side model shifting words onto the three-wire port
`default_nettype none
module spi_host_model (
  output var logic spi_clk_o,
  output var logic spi_le_o,
  output var logic spi_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // frame driver
  // ****************
  initial begin
    spi_clk_o = 1'b0;
    spi_le_o = 1'b1;
    spi_data_o = 1'b0;
  end
  // link clock runs inside frames plus one closing pulse with latch high, 6 ns period, odd phase
  // msb first, latch
  task automatic send(input logic [23:0] word, input int nbits);
    #1.7 spi_le_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_data_o = word[i];
      #3 spi_clk_o = 1'b1;
      #3 spi_clk_o = 1'b0;
    end
    // released data line shows the inverse, not the last bit
    spi_data_o = ~spi_data_o;
    spi_le_o = 1'b1;
    #3 spi_clk_o = 1'b1;
    #3 spi_clk_o = 1'b0;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the serial config register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic spi_clk, spi_le, spi_data, int_mode, cal, strobe;
  logic [23:0] reg_word [8];
  cfg_bank_pkg::cfg_fields_s cfg;
  logic [2:0] wsel;
  int miscompares = 0;
  int checked = 0;
  // one word per select, reserved bits zero
  // reserved written zero
  logic [23:0] words [8] = '{24'h0006a8, 24'h002d29, 24'h001552,
    24'h5aaaab, 24'ha5a5a4, 24'h000a6d, 24'h1a5a5e, 24'h400007};
  always #2.5 sys_clk = ~sys_clk;
  spi_host_model host (.spi_clk_o(spi_clk), .spi_le_o(spi_le),
    .spi_data_o(spi_data));
  pll_mixer_config_registers uut (.SYS_CLK_I(sys_clk), .RESET_I(reset),
    .CLK_EN_I(clk_en), .SPI_CLK_I(spi_clk), .SPI_LE_I(spi_le),
    .SPI_DATA_I(spi_data), .REG_WORD_O(reg_word), .CFG_O(cfg),
    .INTEGER_MODE_O(int_mode), .CAL_START_O(cal), .WRITE_STROBE_O(strobe),
    .WRITE_SEL_O(wsel));
  // ****************
  // helpers
  // ****************
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp,
    input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bounded wait, strobe is read in the cycle it stands
  task automatic wait_strobe(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge sys_clk);
      #1 seen = (strobe === 1'b1);
    end
  endtask
  task automatic write_word(input logic [23:0] w);
    logic seen;
    host.send(w, 24);
    wait_strobe(seen);
    cmp({23'h0, seen}, 24'h1, "strobe");
    cmp({21'h0, wsel}, {21'h0, w[2:0]}, "select");
    cmp({23'h0, cal}, {23'h0, w[2:0] < 3'h3}, "cal start");
    cmp(reg_word[w[2:0]], w, "stored word");
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    logic seen;
    // dummy frame primes the unreset link shifter
    fork
      host.send(24'h000000, 24);
    join_none
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (60) @(posedge sys_clk);
    foreach (words[i]) write_word(words[i]);
    cmp({23'h0, int_mode}, 24'h1, "integer mode");
    cmp({17'h0, cfg.integer_ratio}, 24'h55, "ratio");
    cmp({13'h0, cfg.modulus_value}, 24'h5a5, "modulus");
    cmp({13'h0, cfg.fraction_value}, 24'h2aa, "fraction");
    cmp({23'h0, cfg.ext_osc_enable}, 24'h1, "ext osc");
    $display("test all selects done");
    // new frequency: dividers rewritten close together
    write_word(24'h001552);
    write_word(24'h002d29);
    write_word(24'h0002a8);
    cmp({23'h0, int_mode}, 24'h0, "fractional mode");
    $display("test divider rewrite done");
    // short frame must leave everything alone
    host.send(24'h00fff9, 23);
    wait_strobe(seen);
    cmp({23'h0, seen}, 24'h0, "short frame strobe");
    cmp(reg_word[1], words[1], "short frame word");
    $display("test short frame done");
    final_report();
  end
  // watchdog well past the expected run length
  initial begin
    #30000;
    miscompares++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
